// ===== rtl/serp_pkg.sv
package serp_pkg;

	// ----------------------------------------------------------------
	// memory shape and bus constants
	// ----------------------------------------------------------------
	localparam int         MEM_DEPTH = 256;
	localparam int         ADDR_W    = 8;
	localparam int         BYTE_W    = 8;
	localparam int         SEL_W     = 3;
	localparam int         TYPE_W    = 4;
	localparam int         SYNC_W    = 5;                  // scl, sda and three select pins
	localparam logic [3:0] BITS_DONE = 4'h8;               // bit count after a whole byte
	localparam logic [3:0] CNT_ZERO  = 4'h0;
	localparam logic [7:0] ADDR_TOP  = 8'hFF;
	localparam logic [7:0] ADDR_ZERO = 8'h00;
	localparam logic [7:0] ADDR_ONE  = 8'h01;
	localparam logic       DIR_READ  = 1'h1;
	localparam logic       ACK_LOW   = 1'h0;
	localparam logic [4:0] SYNC_RST  = 5'h03;              // scl and sda idle high

	// ----------------------------------------------------------------
	// slave sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		st_idle,
		st_addr,
		st_addr_ack,
		st_waddr,
		st_waddr_ack,
		st_wdata,
		st_wdata_ack,
		st_rdata,
		st_rack
	} serp_state_e;

endpackage : serp_pkg

// ===== rtl/serp_pin_sync.sv
`timescale 1ns/1ps

module serp_pin_sync #(
	parameter int               W       = 1,
	parameter logic [W-1:0]     RST_VAL = '0
) (
	input  wire logic           ref_clk,
	input  wire logic           nrst,
	input  wire logic [W-1:0]   pin,
	output logic      [W-1:0]   level
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_level;

	// ----------------------------------------------------------------
	// three stages per pin; level moves only when stages two and three agree
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
			end
		end
	endgenerate

	// stage registers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s1    <= RST_VAL;
			s2    <= RST_VAL;
			s3    <= RST_VAL;
			level <= RST_VAL;
		end else begin
			s1    <= pin;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
		end
	end

endmodule : serp_pin_sync

// ===== rtl/serp_eeprom_slave.sv
`timescale 1ns/1ps

module serp_eeprom_slave #(
	parameter logic [3:0] DEV_TYPE = 4'h5                // arbitrary device-type code
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic [2:0] device_select_pins,
	output logic            sda_out,
	output logic            sda_oe
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [serp_pkg::SYNC_W-1:0] pins_level;
	logic                        scl_f;
	logic                        sda_f;
	logic [2:0]                  sel_f;
	logic                        scl_q;
	logic                        sda_q;
	logic                        scl_rise;
	logic                        scl_fall;
	logic                        start_cond;
	logic                        stop_cond;
	logic [7:0]                  mem [serp_pkg::MEM_DEPTH];
	logic [7:0]                  rd_byte;
	serp_pkg::serp_state_e       state;
	serp_pkg::serp_state_e       next_state;
	logic [3:0]                  bitcnt;
	logic [3:0]                  next_bitcnt;
	logic [7:0]                  shreg;
	logic [7:0]                  next_shreg;
	logic [7:0]                  tx;
	logic [7:0]                  next_tx;
	logic [7:0]                  addr;
	logic [7:0]                  next_addr;
	logic                        rw;
	logic                        next_rw;
	logic                        go;
	logic                        next_go;
	logic                        next_oe;
	logic                        wr_en;
	logic                        tx_load;

	// ----------------------------------------------------------------
	// pin conditioning and bus events
	// ----------------------------------------------------------------
	serp_pin_sync #(
		.W       (serp_pkg::SYNC_W),
		.RST_VAL (serp_pkg::SYNC_RST)
	) u_sync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.pin     ({device_select_pins, sda_in, scl_in}),
		.level   (pins_level)
	);

	// split filtered pins and find edges
	assign scl_f      = pins_level[0];
	assign sda_f      = pins_level[1];
	assign sel_f      = pins_level[4:2];
	assign scl_rise   = scl_f & ~scl_q;
	assign scl_fall   = ~scl_f & scl_q;
	assign start_cond = scl_f & scl_q & sda_q & ~sda_f;
	assign stop_cond  = scl_f & scl_q & ~sda_q & sda_f;
	assign rd_byte    = mem[addr];

	// ----------------------------------------------------------------
	// sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state  = state;
		next_bitcnt = bitcnt;
		next_shreg  = shreg;
		next_tx     = tx;
		next_addr   = addr;
		next_rw     = rw;
		next_go     = go;
		next_oe     = sda_oe;
		wr_en       = 1'b0;
		tx_load     = 1'b0;
		if (stop_cond) begin
			next_state = serp_pkg::st_idle;                // standby, line released
			next_oe    = 1'b0;
			next_go    = 1'b0;
		end else if (start_cond) begin
			next_state  = serp_pkg::st_addr;               // also a repeated start; counter kept
			next_bitcnt = serp_pkg::CNT_ZERO;
			next_oe     = 1'b0;
			next_go     = 1'b0;
		end else if (scl_rise) begin
			case (state)
				serp_pkg::st_addr, serp_pkg::st_waddr, serp_pkg::st_wdata,
				serp_pkg::st_rdata: begin
					next_shreg  = {shreg[6:0], sda_f};
					next_bitcnt = bitcnt + 4'h1;
				end
				serp_pkg::st_rack: begin
					if (sda_f == serp_pkg::ACK_LOW) begin
						next_go = 1'b1;
					end else begin
						next_state = serp_pkg::st_idle;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state)
				serp_pkg::st_addr: begin
					if (bitcnt == serp_pkg::BITS_DONE) begin
						if (shreg[7:1] == {DEV_TYPE, sel_f}) begin
							next_oe    = 1'b1;
							next_rw    = shreg[0];
							next_state = serp_pkg::st_addr_ack;
						end else begin
							next_state = serp_pkg::st_idle;
						end
					end
				end
				serp_pkg::st_addr_ack: begin
					if (rw == serp_pkg::DIR_READ) begin
						tx_load = 1'b1;
					end else begin
						next_oe     = 1'b0;
						next_bitcnt = serp_pkg::CNT_ZERO;
						next_state  = serp_pkg::st_waddr;
					end
				end
				serp_pkg::st_waddr: begin
					if (bitcnt == serp_pkg::BITS_DONE) begin
						next_addr  = shreg;
						next_oe    = 1'b1;
						next_state = serp_pkg::st_waddr_ack;
					end
				end
				serp_pkg::st_wdata: begin
					if (bitcnt == serp_pkg::BITS_DONE) begin
						wr_en      = 1'b1;
						next_addr  = addr + serp_pkg::ADDR_ONE;
						next_oe    = 1'b1;
						next_state = serp_pkg::st_wdata_ack;
					end
				end
				serp_pkg::st_waddr_ack, serp_pkg::st_wdata_ack: begin
					next_oe     = 1'b0;
					next_bitcnt = serp_pkg::CNT_ZERO;
					next_state  = serp_pkg::st_wdata;
				end
				serp_pkg::st_rdata: begin
					if (bitcnt == serp_pkg::BITS_DONE) begin
						next_oe    = 1'b0;                     // release for master acknowledge
						next_state = serp_pkg::st_rack;
					end else begin
						next_oe = ~tx[7];
						next_tx = {tx[6:0], 1'b0};
					end
				end
				serp_pkg::st_rack: begin
					if (go) begin
						tx_load = 1'b1;
						next_go = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// first bit of a byte goes out on this fall; counter moves on
		if (tx_load) begin
			next_oe     = ~rd_byte[7];
			next_tx     = {rd_byte[6:0], 1'b0};
			next_addr   = addr + serp_pkg::ADDR_ONE;
			next_bitcnt = serp_pkg::CNT_ZERO;
			next_state  = serp_pkg::st_rdata;
		end
	end

	// ----------------------------------------------------------------
	// sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state   <= serp_pkg::st_idle;
			bitcnt  <= serp_pkg::CNT_ZERO;
			shreg   <= serp_pkg::ADDR_ZERO;
			tx      <= serp_pkg::ADDR_ZERO;
			addr    <= serp_pkg::ADDR_ZERO;
			rw      <= 1'b0;
			go      <= 1'b0;
			sda_oe  <= 1'b0;
			sda_out <= serp_pkg::ACK_LOW;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
		end else begin
			state   <= next_state;
			bitcnt  <= next_bitcnt;
			shreg   <= next_shreg;
			tx      <= next_tx;
			addr    <= next_addr;
			rw      <= next_rw;
			go      <= next_go;
			sda_oe  <= next_oe;
			sda_out <= serp_pkg::ACK_LOW;                  // open drain: only ever pulls low
			scl_q   <= scl_f;
			sda_q   <= sda_f;
		end
	end

	// memory array; written only by data bytes of a write
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[addr] <= shreg;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	chk_read_incr: assert property (
		tx_load |=> addr == $past(addr) + serp_pkg::ADDR_ONE)
		else $error("read did not advance counter");
	chk_write_incr: assert property (
		wr_en |=> addr == $past(addr) + serp_pkg::ADDR_ONE)
		else $error("write did not advance counter");
	chk_addr_ack: assert property (
		$rose(state == serp_pkg::st_addr_ack) |-> sda_oe && !sda_out)
		else $error("matching address not acknowledged");
	chk_first_bit: assert property (
		tx_load |=> sda_oe == ~$past(rd_byte[7]) && state == serp_pkg::st_rdata)
		else $error("first data bit wrong");
	chk_ack_more: assert property (
		state == serp_pkg::st_rack && go && scl_fall && !stop_cond && !start_cond |-> tx_load)
		else $error("acknowledge gave no further byte");
	chk_wrap_zero: assert property (
		tx_load && addr == serp_pkg::ADDR_TOP |=> addr == serp_pkg::ADDR_ZERO)
		else $error("counter did not wrap to zero");
	chk_nack_stop: assert property (
		state == serp_pkg::st_rack && scl_rise && sda_f && !stop_cond && !start_cond
		|=> state == serp_pkg::st_idle ##1 !sda_oe)
		else $error("device kept sending after missing acknowledge");
	chk_no_program: assert property (
		wr_en |-> state == serp_pkg::st_wdata && bitcnt == serp_pkg::BITS_DONE)
		else $error("memory written outside a data byte");
	// a repeated start lands after the word-address ack clock, when the data byte has begun
	chk_restart_keep: assert property (
		start_cond && state == serp_pkg::st_wdata
		|=> addr == $past(addr) && state == serp_pkg::st_addr && !$past(wr_en))
		else $error("repeated start lost word address");

endmodule : serp_eeprom_slave

// ===== sim/serp_bus_master.sv
`timescale 1ns/1ps

module serp_bus_master (
	input  wire logic ref_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// ------------------------------------------------------------
	// bus master model, moves its lines just after ref_clk falls
	// ------------------------------------------------------------
	localparam int HALF = 10;                            // above the device input filter need

	// idle bus: clock stands high, data released
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end

	task automatic pause();
		repeat (HALF) @(negedge ref_clk);
	endtask : pause

	// one clock: hold, set data while low, sample the wire late in the high phase
	task automatic bit_xfer(input logic d, output logic q);
		pause();
		sda_low = ~d;                                    // released line goes to the pull-up
		pause();
		scl = 1'h1;
		pause();
		q = sda;
		scl = 1'h0;
	endtask : bit_xfer

	// start or repeated start, data falls while clock is high
	task automatic start_cond();
		pause();
		sda_low = 1'h0;
		pause();
		scl = 1'h1;
		pause();
		sda_low = 1'h1;
		pause();
		scl = 1'h0;
	endtask : start_cond

	// stop: data rises while clock is high
	task automatic stop_cond();
		pause();
		sda_low = 1'h1;
		pause();
		scl = 1'h1;
		pause();
		sda_low = 1'h0;
		pause();
	endtask : stop_cond

	// send a byte msb first, ninth clock released to sample the acknowledge
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic q;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(b[i], q);
		end
		bit_xfer(1'h1, q);
		ack = ~q;
	endtask : put_byte

	// take a byte, then acknowledge for more or hold data high to finish
	task automatic get_byte(input logic more, output logic [7:0] b);
		logic q;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'h1, b[i]);
		end
		bit_xfer(~more, q);
	endtask : get_byte

endmodule : serp_bus_master

// ===== sim/tb_serial_eeprom_read_path.sv
`timescale 1ns/1ps

module tb_serial_eeprom_read_path;
	localparam logic [3:0] TB_TYPE = 4'hC;               // arbitrary device-type code
	localparam logic [2:0] PINS    = 3'h5;

	logic       ref_clk;
	logic       nrst;
	logic [2:0] device_select_pins;
	logic       scl;
	logic       sda_low;
	logic       sda_out;
	logic       sda_oe;
	wire        sda;
	int         failures;
	int         samples_checked;

	// open-drain wire with pull-up, either party may pull it low
	assign sda = ~((sda_oe & ~sda_out) | sda_low);

	serp_eeprom_slave #(.DEV_TYPE(TB_TYPE)) dut (
		.ref_clk            (ref_clk),
		.nrst               (nrst),
		.scl_in             (scl),
		.sda_in             (sda),
		.device_select_pins (device_select_pins),
		.sda_out            (sda_out),
		.sda_oe             (sda_oe)
	);

	serp_bus_master m (
		.ref_clk (ref_clk),
		.sda     (sda),
		.scl     (scl),
		.sda_low (sda_low)
	);

	always #2 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] pat(input logic [7:0] a);
		return a ^ 8'hA5;
	endfunction : pat

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out

	// start, then type field, pin bits and direction; device acknowledge must match exp
	task automatic address(input logic [2:0] pins, input logic dir, input logic exp);
		logic ack;
		m.start_cond();
		m.put_byte({TB_TYPE, pins, dir}, ack);
		chk({7'h00, ack}, {7'h00, exp});
		chk({7'h00, sda_out}, 8'h00);
	endtask : address

	// read n bytes, acknowledge all but the last, then stop
	task automatic stream(input int n, input logic [7:0] first);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			m.get_byte(i < n - 1, b);
			chk(b, pat(first + 8'(i)));
		end
		m.stop_cond();
	endtask : stream

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic s_write(input logic [7:0] wa, input int n);
		logic ack;
		address(PINS, 1'h0, 1'h1);
		m.put_byte(wa, ack);
		chk({7'h00, ack}, 8'h01);
		for (int i = 0; i < n; i++) begin
			m.put_byte(pat(wa + 8'(i)), ack);
			chk({7'h00, ack}, 8'h01);
		end
		m.stop_cond();
		$display("write from %h done", wa);
	endtask : s_write

	task automatic s_current(input logic [7:0] exp_addr, input int n);
		address(PINS, 1'h1, 1'h1);
		stream(n, exp_addr);
		$display("current read at %h done", exp_addr);
	endtask : s_current

	task automatic s_random(input logic [7:0] wa, input int n);
		logic ack;
		address(PINS, 1'h0, 1'h1);
		m.put_byte(wa, ack);
		chk({7'h00, ack}, 8'h01);
		address(PINS, 1'h1, 1'h1);
		stream(n, wa);
		$display("random read at %h done", wa);
	endtask : s_random

	// wrong pins get no answer; after a finishing byte the device leaves the line
	task automatic s_refuse(input logic [7:0] exp_addr);
		logic [7:0] b;
		logic       q;
		address(PINS ^ 3'h1, 1'h1, 1'h0);
		m.stop_cond();
		device_select_pins = 3'h2;
		address(3'h2, 1'h1, 1'h1);
		m.get_byte(1'h0, b);
		chk(b, pat(exp_addr));
		for (int i = 0; i < 8; i++) begin
			m.bit_xfer(1'h1, q);
			chk({7'h00, q}, 8'h01);
		end
		m.stop_cond();
		device_select_pins = PINS;
		$display("refusal test done");
	endtask : s_refuse

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'h0;
		nrst = 1'h0;
		device_select_pins = PINS;
		failures = 0;
		samples_checked = 0;
		repeat (12) @(negedge ref_clk);
		nrst = 1'h1;
		repeat (8) @(negedge ref_clk);
		s_write(8'h03, 2);
		s_write(8'hFD, 6);
		s_current(8'h03, 1);
		s_random(8'hFD, 5);
		s_current(8'h02, 2);
		s_refuse(8'h04);
		s_random(8'hFF, 3);
		close_out();
	end

	// whole run needs about 10000 cycles
	initial begin
		repeat (40000) @(posedge ref_clk);
		failures++;
		close_out();
	end

endmodule : tb_serial_eeprom_read_path
